// *** hdl/txpf_pkg.sv ***
package txpf_pkg;
  localparam int          FIFO_DEPTH    = 64;
  localparam logic [7:0]  PREAMBLE_BYTE = 8'haa;
  localparam logic [1:0]  LEN_FIXED     = 2'h0;
  localparam logic [1:0]  LEN_VAR       = 2'h1;
  localparam logic [1:0]  LEN_INF       = 2'h2;
  localparam logic [1:0]  SYNC_DOUBLE   = 2'h3;
  localparam logic [1:0]  SYNC_LAST_ONE = 2'h1;
  localparam logic [1:0]  SYNC_LAST_TWO = 2'h3;
  localparam logic [1:0]  MOD_2FSK      = 2'h0;
  localparam logic [1:0]  MOD_4FSK      = 2'h1;
  localparam logic [1:0]  MOD_OOK       = 2'h2;
  localparam logic [1:0]  OFF_IDLE      = 2'h0;
  localparam logic [1:0]  OFF_FSTXON    = 2'h1;
  localparam logic [1:0]  OFF_TX        = 2'h2;
  localparam logic [5:0]  SEL_FIFO_THR  = 6'h02;
  localparam logic [5:0]  SEL_FIFO_FULL = 6'h03;
  localparam logic [5:0]  SEL_SYNC_PKT  = 6'h06;
  localparam logic [15:0] CRC_POLY      = 16'h8005;
  localparam logic [15:0] CRC_INIT      = 16'hffff;
  localparam logic [3:0]  DEV_BASE      = 4'h8;
  localparam logic [3:0]  SYMS_2LVL     = 4'h8;
  localparam logic [3:0]  SYMS_4LVL     = 4'h4;

  typedef enum logic [2:0] {
    TXPF_IDLE      = 3'b000,
    TXPF_FSTXON    = 3'b001,
    TXPF_PREAMBLE  = 3'b010,
    TXPF_SYNC      = 3'b011,
    TXPF_DATA      = 3'b100,
    TXPF_CRC       = 3'b101,
    TXPF_UNDERFLOW = 3'b110
  } txpf_state_e;

  typedef struct packed {
    logic [1:0] length_select;
    logic       crc_en;
    logic [1:0] sync_mode;
    logic [1:0] mod_format;
    logic       manch_en;
    logic [1:0] after_tx_state;
    logic [4:0] preamble_bytes;
    logic [7:0] packet_length_value;
    logic [7:0] sync_high_byte;
    logic [7:0] sync_low_byte;
    logic [2:0] dev_m;
    logic [2:0] dev_e;
  } txpf_cfg_s;

  typedef struct packed {
    logic [7:0]  data;
    logic        four_level;
    logic        manch;
    logic        ook;
    logic [10:0] dev_full;
  } txpf_byte_s;
endpackage : txpf_pkg

// *** hdl/txpf_top.sv ***
`timescale 1ns/1ps
`default_nettype none
module txpf_top #(
  parameter int FIFO_THR = 33
) (
  // clocks and reset
  input  wire logic                 clk_sys,
  input  wire logic                 sys_rst,
  input  wire logic                 clk_link,
  // controller side
  input  wire logic                 fifo_wr_en,
  input  wire logic [7:0]           fifo_wr_data,
  input  wire logic                 tx_start_strobe,
  input  wire logic                 tx_stop_strobe,
  input  wire logic                 flush_tx_strobe,
  input  wire txpf_pkg::txpf_cfg_s  cfg,
  input  wire logic [5:0]           pin_sel_zero,
  input  wire logic [5:0]           pin_sel_two,
  // status
  output logic                      status_pin_zero,
  output logic                      status_pin_two,
  output logic [1:0]                pin_level_status,
  output logic [6:0]                fifo_fill_count,
  output logic [2:0]                radio_state,
  // link side
  output logic signed [11:0]        freq_dev,
  output logic                      pa_on,
  output logic                      sym_valid
);
  localparam int PW = $clog2(txpf_pkg::FIFO_DEPTH);

  function automatic logic [15:0] crc_byte(input logic [15:0] c, input logic [7:0] d);
    logic [15:0] r;
    r = c;
    for (int i = 7; i >= 0; i--) begin
      r = (r[15] ^ d[i]) ? ((r << 1) ^ txpf_pkg::CRC_POLY) : (r << 1);
    end
    return r;
  endfunction : crc_byte
  function automatic logic pin_mux(input logic [5:0] sel, input logic thr, input logic full,
                                   input logic pkt);
    case (sel)
      txpf_pkg::SEL_FIFO_THR:  pin_mux = thr;
      txpf_pkg::SEL_FIFO_FULL: pin_mux = full;
      txpf_pkg::SEL_SYNC_PKT:  pin_mux = pkt;
      default:                 pin_mux = 1'b0;
    endcase
  endfunction : pin_mux
  function automatic txpf_pkg::txpf_state_e after_state(input logic [1:0] sel);
    case (sel)
      txpf_pkg::OFF_TX:     after_state = txpf_pkg::TXPF_PREAMBLE;
      txpf_pkg::OFF_FSTXON: after_state = txpf_pkg::TXPF_FSTXON;
      default:              after_state = txpf_pkg::TXPF_IDLE;
    endcase
  endfunction : after_state
  txpf_pkg::txpf_state_e state_r;
  logic [7:0]            mem_r [txpf_pkg::FIFO_DEPTH];
  logic [PW-1:0]         wr_ptr_r;
  logic [PW-1:0]         rd_ptr_r;
  logic [PW:0]           count_r;
  logic [4:0]            pre_cnt_r;
  logic [1:0]            sync_idx_r;
  logic [8:0]            byte_cnt_r;
  logic [7:0]            len_byte_r;
  logic                  crc_idx_r;
  logic [15:0]           crc_r;
  logic                  pkt_active_r;
  logic                  req_r;
  logic                  ack_s1_r;
  logic                  ack_s2_r;
  logic                  ack_r;
  txpf_pkg::txpf_byte_s  hs_r;
  logic        fifo_empty;
  logic        fifo_full;
  logic        hs_free;
  logic        flush_ok;
  logic        send;
  logic        pop;
  logic [7:0]  send_data;
  logic        send_four;
  logic [8:0]  cnt_nxt;
  logic        data_done;
  logic [10:0] dev_full;
  assign fifo_empty = (count_r == '0);
  assign fifo_full  = (count_r == (PW+1)'(txpf_pkg::FIFO_DEPTH));
  assign hs_free    = (req_r == ack_s2_r);
  assign flush_ok   = flush_tx_strobe &&
                      (state_r == txpf_pkg::TXPF_IDLE || state_r == txpf_pkg::TXPF_UNDERFLOW);
  assign cnt_nxt    = byte_cnt_r + 9'h001;
  assign dev_full   = 11'({txpf_pkg::DEV_BASE + {1'b0, cfg.dev_m}} << cfg.dev_e);
  // what the framer hands to the link this cycle
  always_comb begin
    send      = 1'b0;
    pop       = 1'b0;
    send_data = txpf_pkg::PREAMBLE_BYTE;
    send_four = 1'b0;
    case (state_r)
      txpf_pkg::TXPF_PREAMBLE: send = hs_free;
      txpf_pkg::TXPF_SYNC: begin
        send      = hs_free;
        send_data = sync_idx_r[0] ? cfg.sync_low_byte : cfg.sync_high_byte;
      end
      txpf_pkg::TXPF_DATA: begin
        send      = hs_free && !fifo_empty;
        pop       = send;
        send_data = mem_r[rd_ptr_r];
        send_four = (cfg.mod_format == txpf_pkg::MOD_4FSK);
      end
      txpf_pkg::TXPF_CRC: begin
        send      = hs_free;
        send_data = crc_idx_r ? crc_r[7:0] : crc_r[15:8];
      end
      default: send = 1'b0;
    endcase
  end
  // end of payload, length mode read live so it may be switched mid packet
  always_comb begin
    case (cfg.length_select)
      txpf_pkg::LEN_FIXED: data_done = (cnt_nxt[7:0] == cfg.packet_length_value);
      txpf_pkg::LEN_VAR:   data_done = (byte_cnt_r != '0) &&
                                       (cnt_nxt == {1'b0, len_byte_r} + 9'h001);
      default:             data_done = 1'b0;
    endcase
  end
  // transmit fifo
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      count_r  <= '0;
    end else if (flush_ok) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      count_r  <= '0;
    end else begin
      if (fifo_wr_en && !fifo_full) begin
        wr_ptr_r <= wr_ptr_r + PW'(1);
      end
      if (pop) begin
        rd_ptr_r <= rd_ptr_r + PW'(1);
      end
      count_r <= count_r + (PW+1)'(fifo_wr_en && !fifo_full) - (PW+1)'(pop);
    end
  end

  always_ff @(posedge clk_sys) begin
    if (fifo_wr_en && !fifo_full) begin
      mem_r[wr_ptr_r] <= fifo_wr_data;
    end
  end
  // packet sequencer
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      state_r      <= txpf_pkg::TXPF_IDLE;
      pre_cnt_r    <= '0;
      sync_idx_r   <= '0;
      byte_cnt_r   <= '0;
      len_byte_r   <= '0;
      crc_idx_r    <= 1'b0;
      pkt_active_r <= 1'b0;
    end else if (tx_stop_strobe && state_r != txpf_pkg::TXPF_UNDERFLOW) begin
      state_r      <= txpf_pkg::TXPF_IDLE;
      pkt_active_r <= 1'b0;
    end else begin
      case (state_r)
        txpf_pkg::TXPF_IDLE, txpf_pkg::TXPF_FSTXON: begin
          if (tx_start_strobe) begin
            state_r   <= txpf_pkg::TXPF_PREAMBLE;
            pre_cnt_r <= '0;
          end
        end
        txpf_pkg::TXPF_PREAMBLE: begin
          if (send) begin
            if (pre_cnt_r != '1) begin
              pre_cnt_r <= pre_cnt_r + 5'h01;
            end
            if ({1'b0, pre_cnt_r} + 6'h01 >= {1'b0, cfg.preamble_bytes} && !fifo_empty) begin
              state_r    <= txpf_pkg::TXPF_SYNC;
              sync_idx_r <= '0;
            end
          end
        end
        txpf_pkg::TXPF_SYNC: begin
          if (send) begin
            sync_idx_r <= sync_idx_r + 2'h1;
            if (sync_idx_r == ((cfg.sync_mode == txpf_pkg::SYNC_DOUBLE) ?
                               txpf_pkg::SYNC_LAST_TWO : txpf_pkg::SYNC_LAST_ONE)) begin
              state_r      <= txpf_pkg::TXPF_DATA;
              byte_cnt_r   <= '0;
              pkt_active_r <= 1'b1;
            end
          end
        end
        txpf_pkg::TXPF_DATA: begin
          if (send) begin
            byte_cnt_r <= cnt_nxt;
            if (byte_cnt_r == '0) begin
              len_byte_r <= send_data;
            end
            if (data_done) begin
              crc_idx_r <= 1'b0;
              if (cfg.crc_en) begin
                state_r <= txpf_pkg::TXPF_CRC;
              end else begin
                pkt_active_r <= 1'b0;
                state_r      <= after_state(cfg.after_tx_state);
                pre_cnt_r <= '0;
              end
            end
          end else if (hs_free && fifo_empty) begin
            state_r      <= txpf_pkg::TXPF_UNDERFLOW;
            pkt_active_r <= 1'b0;
          end
        end
        txpf_pkg::TXPF_CRC: begin
          if (send) begin
            crc_idx_r <= 1'b1;
            if (crc_idx_r) begin
              pkt_active_r <= 1'b0;
              state_r      <= after_state(cfg.after_tx_state);
              pre_cnt_r <= '0;
            end
          end
        end
        txpf_pkg::TXPF_UNDERFLOW: begin
          if (flush_ok) begin
            state_r <= txpf_pkg::TXPF_IDLE;
          end
        end
        default: state_r <= txpf_pkg::TXPF_IDLE;
      endcase
    end
  end
  // checksum over every byte pulled from the fifo
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      crc_r <= txpf_pkg::CRC_INIT;
    end else if (state_r == txpf_pkg::TXPF_SYNC) begin
      crc_r <= txpf_pkg::CRC_INIT;
    end else if (pop) begin
      crc_r <= crc_byte(crc_r, send_data);
    end
  end

  // byte handover to the link domain: toggle request, data held until acknowledged
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      req_r    <= 1'b0;
      ack_s1_r <= 1'b0;
      ack_s2_r <= 1'b0;
      hs_r     <= '0;
    end else begin
      ack_s1_r <= ack_r;
      ack_s2_r <= ack_s1_r;
      if (send) begin
        req_r         <= ~req_r;
        hs_r.data     <= send_data;
        hs_r.four_level <= send_four;
        hs_r.manch    <= cfg.manch_en && !send_four;
        hs_r.ook      <= (cfg.mod_format == txpf_pkg::MOD_OOK);
        hs_r.dev_full <= dev_full;
      end
    end
  end

  // status outputs
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      status_pin_zero <= 1'b0;
      status_pin_two  <= 1'b0;
    end else begin
      status_pin_zero <= pin_mux(pin_sel_zero, count_r >= (PW+1)'(FIFO_THR), fifo_full, pkt_active_r);
      status_pin_two  <= pin_mux(pin_sel_two, count_r >= (PW+1)'(FIFO_THR), fifo_full, pkt_active_r);
    end
  end

  assign pin_level_status = {status_pin_two, status_pin_zero};
  assign fifo_fill_count  = 7'(count_r);
  assign radio_state      = state_r;

  // link domain: reset release synchronised, symbols shifted on the link clock
  logic                 lrst_s1_r;
  logic                 lrst_r;
  logic                 req_s1_r;
  logic                 req_s2_r;
  logic [7:0]           sh_r;
  logic [3:0]           left_r;
  logic                 half_r;
  txpf_pkg::txpf_byte_s cur_r;
  logic                 pending;
  logic                 ending;
  logic                 chip;
  logic signed [11:0]   dev_nxt;
  logic [10:0]          third;
  always_ff @(posedge clk_link or posedge sys_rst) begin
    if (sys_rst) begin
      lrst_s1_r <= 1'b1;
      lrst_r    <= 1'b1;
    end else begin
      lrst_s1_r <= 1'b0;
      lrst_r    <= lrst_s1_r;
    end
  end
  assign pending = (req_s2_r != ack_r);
  assign ending  = (left_r == 4'h1) && (!cur_r.manch || half_r);
  assign chip    = (cur_r.manch && half_r) ? ~sh_r[7] : sh_r[7];
  assign third   = cur_r.dev_full / 11'h003;
  always_comb begin
    if (cur_r.four_level) begin
      case (sh_r[7:6])
        2'b01:   dev_nxt = -$signed({1'b0, cur_r.dev_full});
        2'b00:   dev_nxt = -$signed({1'b0, third});
        2'b10:   dev_nxt = $signed({1'b0, third});
        default: dev_nxt = $signed({1'b0, cur_r.dev_full});
      endcase
    end else begin
      dev_nxt = chip ? $signed({1'b0, cur_r.dev_full}) : -$signed({1'b0, cur_r.dev_full});
    end
  end

  always_ff @(posedge clk_link or posedge lrst_r) begin
    if (lrst_r) begin
      req_s1_r <= 1'b0;
      req_s2_r <= 1'b0;
      ack_r    <= 1'b0;
      sh_r     <= '0;
      left_r   <= '0;
      half_r   <= 1'b0;
      cur_r    <= '0;
    end else begin
      req_s1_r <= req_r;
      req_s2_r <= req_s1_r;
      if ((left_r == '0 || ending) && pending) begin
        sh_r   <= hs_r.data;
        cur_r  <= hs_r;
        left_r <= hs_r.four_level ? txpf_pkg::SYMS_4LVL : txpf_pkg::SYMS_2LVL;
        half_r <= 1'b0;
        ack_r  <= ~ack_r;
      end else if (ending) begin
        left_r <= '0;
      end else if (left_r != '0) begin
        if (cur_r.manch && !half_r) begin
          half_r <= 1'b1;
        end else begin
          half_r <= 1'b0;
          sh_r   <= cur_r.four_level ? {sh_r[5:0], 2'b00} : {sh_r[6:0], 1'b0};
          left_r <= left_r - 4'h1;
        end
      end
    end
  end

  always_ff @(posedge clk_link or posedge lrst_r) begin
    if (lrst_r) begin
      sym_valid <= 1'b0;
      pa_on     <= 1'b0;
      freq_dev  <= '0;
    end else begin
      sym_valid <= (left_r != '0);
      pa_on     <= (left_r != '0) && (!cur_r.ook || chip);
      freq_dev  <= (left_r != '0 && !cur_r.ook) ? dev_nxt : '0;
    end
  end

  a_pre_pattern: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (send && state_r == txpf_pkg::TXPF_PREAMBLE) |=> (hs_r.data == txpf_pkg::PREAMBLE_BYTE))
    else $error("preamble byte not alternating pattern");
  a_pre_wait: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (state_r == txpf_pkg::TXPF_PREAMBLE && fifo_empty && !tx_stop_strobe) |=> state_r == txpf_pkg::TXPF_PREAMBLE)
    else $error("left preamble with empty fifo");
  a_sync_entry: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (state_r == txpf_pkg::TXPF_SYNC && $past(state_r) != txpf_pkg::TXPF_SYNC) |->
    $past(state_r) == txpf_pkg::TXPF_PREAMBLE)
    else $error("sync not preceded by preamble");
  a_sync_high: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (send && state_r == txpf_pkg::TXPF_SYNC && sync_idx_r == 2'h0) |=> hs_r.data == $past(cfg.sync_high_byte))
    else $error("sync high byte not first");
  a_uflow_hold: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (state_r == txpf_pkg::TXPF_UNDERFLOW && !flush_tx_strobe) |=> state_r == txpf_pkg::TXPF_UNDERFLOW)
    else $error("underflow left without flush");
  a_flush_gate: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (flush_tx_strobe && !flush_ok && !pop) |=> count_r >= $past(count_r))
    else $error("flush accepted outside idle or underflow");
  a_two_level: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (send && state_r != txpf_pkg::TXPF_DATA) |=> !hs_r.four_level)
    else $error("preamble or sync sent four level");
  a_pin_pkt: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (pin_sel_zero == txpf_pkg::SEL_SYNC_PKT) |=> status_pin_zero == $past(pkt_active_r))
    else $error("status pin does not follow packet activity");
  a_ook_pa: assert property (@(posedge clk_link) disable iff (lrst_r)
    (left_r != '0 && cur_r.ook) |=> (pa_on == $past(chip) && freq_dev == '0))
    else $error("ook amplifier level wrong");
  a_manch_inv: assert property (@(posedge clk_link) disable iff (lrst_r)
    (left_r != '0 && cur_r.manch && !half_r && !cur_r.ook) ##1 (left_r != '0) |=>
    freq_dev == -$past(freq_dev))
    else $error("manchester halves not inverted");
endmodule : txpf_top
`default_nettype wire

// *** verification/txpf_link_rx.sv ***
`timescale 1ns/1ps
`default_nettype none
module txpf_link_rx (
  // link symbols
  input  wire logic               clk_link,
  input  wire logic signed [11:0] freq_dev,
  input  wire logic               pa_on,
  input  wire logic               sym_valid,
  // bench control
  input  wire logic               rx_clr,
  input  wire logic [10:0]        dev_full,
  // captured symbols as {amplifier, level pair}
  output logic [2:0]              sym_log [0:4095],
  output var int                  n_sym,
  output logic                    bad_idle
);
  logic [1:0] code;

  // level pair per deviation: full swings are exact, thirds anything in between
  always_comb begin
    if (freq_dev == $signed({1'b0, dev_full})) code = 2'h3;
    else if (freq_dev == -$signed({1'b0, dev_full})) code = 2'h1;
    else if (freq_dev > 12'sh000) code = 2'h2;
    else code = 2'h0;
  end

  always_ff @(posedge clk_link) begin
    if (rx_clr) begin
      n_sym    <= 0;
      bad_idle <= 1'b0;
    end else if (sym_valid) begin
      sym_log[n_sym[11:0]] <= {pa_on, code};
      n_sym                <= n_sym + 1;
    end else if (pa_on) begin
      bad_idle <= 1'b1;
    end
  end
endmodule : txpf_link_rx
`default_nettype wire

// *** verification/tb_top.sv ***
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  localparam int THR = 33;
  logic                clk_sys = 1'b0;
  logic                clk_link = 1'b0;
  logic                sys_rst = 1'b1;
  logic                fifo_wr_en = 1'b0;
  logic [7:0]          fifo_wr_data = 8'h00;
  logic [2:0]          stb = 3'h0;
  txpf_pkg::txpf_cfg_s cfg;
  logic [5:0]          pin_sel_zero = txpf_pkg::SEL_FIFO_FULL;
  logic [5:0]          pin_sel_two = txpf_pkg::SEL_FIFO_THR;
  logic                status_pin_zero;
  logic                status_pin_two;
  logic [1:0]          pin_level_status;
  logic [6:0]          fifo_fill_count;
  logic [2:0]          radio_state;
  logic signed [11:0]  freq_dev;
  logic                pa_on;
  logic                sym_valid;
  logic                rx_clr = 1'b0;
  logic [10:0]         dev_full;
  logic [2:0]          sym_log [0:4095];
  int                  n_sym;
  logic                bad_idle;
  int                  n_mismatch = 0;
  int                  tests_run = 0;
  int                  cyc = 0;
  int                  rp;
  logic                saw_pkt;
  logic [15:0]         crc_v;
  logic [7:0]          q[$];

  always #20 clk_sys = ~clk_sys;
  always #16 clk_link = ~clk_link;
  assign dev_full = (11'h008 + {8'h00, cfg.dev_m}) << cfg.dev_e;

  txpf_top #(.FIFO_THR(THR)) dut (
    .clk_sys(clk_sys), .sys_rst(sys_rst), .clk_link(clk_link), .fifo_wr_en(fifo_wr_en),
    .fifo_wr_data(fifo_wr_data), .tx_start_strobe(stb[0]), .tx_stop_strobe(stb[1]), .flush_tx_strobe(stb[2]),
    .cfg(cfg), .pin_sel_zero(pin_sel_zero), .pin_sel_two(pin_sel_two), .status_pin_zero(status_pin_zero),
    .status_pin_two(status_pin_two), .pin_level_status(pin_level_status), .fifo_fill_count(fifo_fill_count),
    .radio_state(radio_state), .freq_dev(freq_dev), .pa_on(pa_on), .sym_valid(sym_valid));
  txpf_link_rx link_rx (
    .clk_link(clk_link), .freq_dev(freq_dev), .pa_on(pa_on), .sym_valid(sym_valid), .rx_clr(rx_clr),
    .dev_full(dev_full), .sym_log(sym_log), .n_sym(n_sym), .bad_idle(bad_idle));

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic final_report();
    if (n_mismatch == 0 && tests_run > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : final_report

  task automatic settle(input int n);
    repeat (n) @(posedge clk_sys);
    @(negedge clk_sys);
  endtask : settle

  task automatic pulse(input logic [2:0] s);
    @(posedge clk_sys);
    stb <= s;
    @(posedge clk_sys);
    stb <= 3'h0;
  endtask : pulse

  task automatic wr(input logic [7:0] d[$]);
    foreach (d[i]) begin
      @(posedge clk_sys);
      fifo_wr_en   <= 1'b1;
      fifo_wr_data <= d[i];
    end
    @(posedge clk_sys);
    fifo_wr_en <= 1'b0;
  endtask : wr

  task automatic wait_for(input logic [2:0] st);
    int k;
    k = 0;
    @(negedge clk_sys);
    while (radio_state !== st && k < 2000) begin
      @(negedge clk_sys);
      if (status_pin_zero === 1'b1) saw_pkt = 1'b1;
      k++;
    end
    chk({29'h0, radio_state}, {29'h0, st});
  endtask : wait_for

  // packet settings change here while idle; the long-packet test switches length mid packet
  task automatic setup(input logic [1:0] ls, input logic crc, input logic [1:0] sm, input logic [1:0] mf,
                       input logic mc, input logic [1:0] at, input logic [7:0] pl);
    @(posedge clk_sys);
    cfg.length_select       <= ls;
    cfg.crc_en              <= crc;
    cfg.sync_mode           <= sm;
    cfg.mod_format          <= mf;
    cfg.manch_en            <= mc;
    cfg.after_tx_state      <= at;
    cfg.packet_length_value <= pl;
    pin_sel_zero            <= txpf_pkg::SEL_SYNC_PKT;
    rx_clr                  <= 1'b1;
    repeat (3) @(posedge clk_sys);
    rx_clr <= 1'b0;
    saw_pkt = 1'b0;
  endtask : setup

  function automatic logic [15:0] crc16(input logic [7:0] d[$]);
    logic [15:0] c;
    c = txpf_pkg::CRC_INIT;
    foreach (d[i])
      for (int j = 7; j >= 0; j--) c = {c[14:0], 1'b0} ^ ((c[15] ^ d[i][j]) ? txpf_pkg::CRC_POLY : 16'h0000);
    return c;
  endfunction : crc16

  function automatic logic sbit(input logic [2:0] c);
    return (cfg.mod_format === txpf_pkg::MOD_OOK) ? c[2] : c[1];
  endfunction : sbit

  task automatic take(input logic four, output logic [7:0] b);
    logic [2:0] c;
    int         n;
    b = 8'h00;
    n = 0;
    while (n < 8) begin
      c = sym_log[rp[11:0]];
      rp++;
      if (four) begin
        b = {b[5:0], c[1:0]};
        n += 2;
      end else begin
        b = {b[6:0], sbit(c)};
        n++;
        if (cfg.mod_format !== txpf_pkg::MOD_OOK) chk({31'h0, c[0]}, 32'h1);
      end
      if (cfg.manch_en === 1'b1) begin
        chk({31'h0, sbit(sym_log[rp[11:0]])}, {31'h0, ~sbit(c)});
        rp++;
      end
    end
  endtask : take

  task automatic check_frame(input logic dbl, input logic four, input logic [7:0] e[$]);
    logic [7:0] b;
    int         np;
    int         sv;
    rp = 0;
    np = 0;
    b = txpf_pkg::PREAMBLE_BYTE;
    while (b === txpf_pkg::PREAMBLE_BYTE) begin
      sv = rp;
      take(1'b0, b);
      np++;
    end
    rp = sv;
    chk({31'h0, np > int'(cfg.preamble_bytes)}, 32'h1);
    repeat (dbl ? 2 : 1) begin
      take(1'b0, b);
      chk({24'h0, b}, {24'h0, cfg.sync_high_byte});
      take(1'b0, b);
      chk({24'h0, b}, {24'h0, cfg.sync_low_byte});
    end
    foreach (e[i]) begin
      take(four, b);
      chk({24'h0, b}, {24'h0, e[i]});
    end
    chk({31'h0, bad_idle}, 32'h0);
  endtask : check_frame

  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      n_mismatch++;
      final_report();
    end
  end

  initial begin
    cfg = '0;
    cfg.preamble_bytes = 5'h02;
    cfg.sync_high_byte = 8'hd3;
    cfg.sync_low_byte = 8'h91;
    cfg.dev_m = 3'h3;
    cfg.dev_e = 3'h2;
    repeat (3) @(posedge clk_sys);
    sys_rst <= 1'b0;
    settle(1);
    chk({22'h0, radio_state, fifo_fill_count}, 32'h0);
    // fifo level pins: threshold, full, dropped write, flush
    q = {};
    for (int i = 0; i < THR - 1; i++) q.push_back(8'(i));
    wr(q);
    settle(2);
    chk({31'h0, status_pin_two}, 32'h0);
    wr({8'h55});
    settle(2);
    chk({30'h0, pin_level_status}, 32'h2);
    wr(q);
    settle(2);
    chk({23'h0, fifo_fill_count, pin_level_status}, {23'h0, 7'h40, 2'h3});
    pulse(3'h4);
    settle(2);
    chk({23'h0, fifo_fill_count, pin_level_status}, 32'h0);
    // fixed length with checksum
    setup(txpf_pkg::LEN_FIXED, 1'b1, txpf_pkg::SYNC_LAST_ONE, txpf_pkg::MOD_2FSK, 1'b1, txpf_pkg::OFF_IDLE, 8'h03);
    q = {8'h11, 8'h80, 8'h7e};
    wr(q);
    pulse(3'h1);
    settle(1);
    chk({29'h0, radio_state}, {29'h0, txpf_pkg::TXPF_PREAMBLE});
    wait_for(txpf_pkg::TXPF_IDLE);
    chk({31'h0, saw_pkt}, 32'h1);
    settle(40);
    crc_v = crc16(q);
    q.push_back(crc_v[15:8]);
    q.push_back(crc_v[7:0]);
    check_frame(1'b0, 1'b0, q);
    chk(n_sym, rp);
    // variable length, four-level, double sync, started on an empty fifo
    setup(txpf_pkg::LEN_VAR, 1'b0, txpf_pkg::SYNC_DOUBLE, txpf_pkg::MOD_4FSK, 1'b0, txpf_pkg::OFF_FSTXON, 8'h40);
    pulse(3'h1);
    settle(60);
    chk({29'h0, radio_state}, {29'h0, txpf_pkg::TXPF_PREAMBLE});
    pulse(3'h4);
    settle(2);
    chk({29'h0, radio_state}, {29'h0, txpf_pkg::TXPF_PREAMBLE});
    q = {8'h02, 8'h1b, 8'he4};
    wr(q);
    wait_for(txpf_pkg::TXPF_FSTXON);
    settle(40);
    check_frame(1'b1, 1'b1, q);
    chk(n_sym, rp);
    pulse(3'h1);
    settle(2);
    chk({29'h0, radio_state}, {29'h0, txpf_pkg::TXPF_PREAMBLE});
    pulse(3'h2);
    wait_for(txpf_pkg::TXPF_IDLE);
    // unlimited length runs dry: underflow holds until flushed
    setup(txpf_pkg::LEN_INF, 1'b0, txpf_pkg::SYNC_LAST_ONE, txpf_pkg::MOD_2FSK, 1'b0, txpf_pkg::OFF_IDLE, 8'h01);
    wr({8'h31, 8'h32});
    pulse(3'h1);
    wait_for(txpf_pkg::TXPF_UNDERFLOW);
    wr({8'h33});
    pulse(3'h2);
    settle(30);
    chk({29'h0, radio_state}, {29'h0, txpf_pkg::TXPF_UNDERFLOW});
    pulse(3'h4);
    wait_for(txpf_pkg::TXPF_IDLE);
    chk({25'h0, fifo_fill_count}, 32'h0);
    // long-packet switch from unlimited to fixed mid-packet, then back to preamble and stopped
    setup(txpf_pkg::LEN_INF, 1'b1, txpf_pkg::SYNC_LAST_ONE, txpf_pkg::MOD_2FSK, 1'b0, txpf_pkg::OFF_TX, 8'h05);
    q = {8'ha1, 8'ha2, 8'ha3, 8'ha4, 8'ha5};
    wr(q);
    pulse(3'h1);
    wait_for(txpf_pkg::TXPF_DATA);
    @(posedge clk_sys);
    cfg.length_select <= txpf_pkg::LEN_FIXED;
    wait_for(txpf_pkg::TXPF_CRC);
    wait_for(txpf_pkg::TXPF_PREAMBLE);
    pulse(3'h2);
    wait_for(txpf_pkg::TXPF_IDLE);
    settle(40);
    crc_v = crc16(q);
    q.push_back(crc_v[15:8]);
    q.push_back(crc_v[7:0]);
    check_frame(1'b0, 1'b0, q);
    // on-off keying with manchester chips
    setup(txpf_pkg::LEN_FIXED, 1'b0, txpf_pkg::SYNC_LAST_ONE, txpf_pkg::MOD_OOK, 1'b1, txpf_pkg::OFF_IDLE, 8'h01);
    q = {8'h4b};
    wr(q);
    pulse(3'h1);
    wait_for(txpf_pkg::TXPF_IDLE);
    settle(60);
    check_frame(1'b0, 1'b0, q);
    chk(n_sym, rp);
    final_report();
  end
endmodule : tb_top
`default_nettype wire
